// [verilog/timer_pin_io_control.sv]
// Purpose: Pin function control for the channel 0 D and channel 1 B general registers.
// Assumes: Counters, count tick and C event come from logic on the same clock.
// Notes:   Zero wait state AHB-Lite slave; answer is always OKAY.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module timer_pin_io_control
	import timer_pin_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  wire logic [CNT_W-1:0] ch0_count,
	input  wire logic [CNT_W-1:0] ch1_count,
	input  wire logic             ch1_count_tick,
	input  wire logic             ch0_c_event,
	input  wire logic             ch0_pin_d_in,
	output logic                  ch0_pin_d_out,
	output logic                  ch0_pin_d_oe,
	input  wire logic             ch1_pin_b_in,
	output logic                  ch1_pin_b_out,
	output logic                  ch1_pin_b_oe,
	output logic                  irq
);

	logic [CTRL_W-1:0] ctrl_r [CH_N];
	logic [RUN_W-1:0]  run_r;
	logic [CH_N-1:0]   stat_r;
	logic [CH_N-1:0]   en_r;
	logic [ADDR_W-1:0] dp_addr_r;
	logic              dp_wr_r;
	logic              dp_rd_r;
	logic              ap_take;
	logic [CH_N-1:0]   sync1_r;
	logic [CH_N-1:0]   sync2_r;
	logic [CH_N-1:0]   pin_in_v;
	logic [CH_N-1:0]   pin_v;
	logic [CH_N-1:0]   oe_v;
	logic [CH_N-1:0]   match_v;
	logic [CH_N-1:0]   cap_v;
	logic [CH_N-1:0]   rise_v;
	logic [CH_N-1:0]   fall_v;
	logic [CH_N-1:0]   start_v;
	logic [CH_N-1:0]   inh_v;
	logic [CH_N-1:0]   src_v;
	logic [CH_N-1:0]   we_v;
	logic [CH_N-1:0]   evt_v;
	logic [CH_N-1:0]   clr_v;
	logic [3:0]        func_v [CH_N];
	logic [CNT_W-1:0]  count_v [CH_N];
	logic [CNT_W-1:0]  gen_v [CH_N];
	logic [31:0]       rd_mux;

	// Bus address phase.
	assign ap_take = hsel && hready && htrans[HTRANS_ACT];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_addr_r <= '0;
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
		end
		else if (hready)
		begin
			dp_addr_r <= haddr[ADDR_W-1:0];
			dp_wr_r <= ap_take && hwrite && (hsize == SIZE_WORD);
			dp_rd_r <= ap_take && !hwrite;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_r[0] <= CTRL_RST;
			ctrl_r[1] <= CTRL_RST;
		end
		else if (dp_wr_r)
		begin
			if (dp_addr_r == OFS_CH0_CTRL)
				ctrl_r[0] <= hwdata[CTRL_W-1:0];
			else if (dp_addr_r == OFS_CH1_CTRL)
				ctrl_r[1] <= hwdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			run_r <= RUN_RST;
		else if (dp_wr_r && dp_addr_r == OFS_RUN_CTRL)
			run_r <= hwdata[RUN_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			en_r <= EVT_RST;
		else if (dp_wr_r && dp_addr_r == OFS_EVT_EN)
			en_r <= hwdata[CH_N-1:0];
	end

	assign clr_v = (dp_wr_r && dp_addr_r == OFS_EVT_CLR) ? hwdata[CH_N-1:0] : EVT_RST;

	// A new event in the clearing cycle stays set, so none is lost.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			stat_r <= EVT_RST;
		else
			stat_r <= (stat_r & ~clr_v) | evt_v;
	end

	assign irq = |(stat_r & en_r);

	// Pins come from outside the clock domain.
	assign pin_in_v = {ch1_pin_b_in, ch0_pin_d_in};

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pin_in_v;
			sync2_r <= sync1_r;
		end
	end

	// Per channel wiring; channel 0 is the D register, channel 1 the B register.
	assign count_v[0] = ch0_count;
	assign count_v[1] = ch1_count;
	assign start_v = {run_r[RB_START1], run_r[RB_START0]};
	assign inh_v = {1'b0, run_r[RB_BUF]};
	assign src_v = {ch0_c_event, ch1_count_tick};
	assign we_v[0] = dp_wr_r && dp_addr_r == OFS_CH0_GEN;
	assign we_v[1] = dp_wr_r && dp_addr_r == OFS_CH1_GEN;

	generate
		for (genvar i = 0; i < CH_N; i++)
		begin : g_ch
			chan_if #(.CW(CNT_W)) cif ();

			assign func_v[i] = ctrl_r[i][FUNC_MSB:FUNC_LSB];
			assign cif.func = func_v[i];
			assign cif.start = start_v[i];
			assign cif.inhibit = inh_v[i];
			assign cif.count = count_v[i];
			assign cif.int_src = src_v[i];
			assign cif.lvl = sync2_r[i];
			assign cif.gen_we = we_v[i];
			assign cif.gen_wdata = hwdata[CNT_W-1:0];
			assign gen_v[i] = cif.gen_q;
			assign pin_v[i] = cif.pin_q;
			assign oe_v[i] = cif.pin_oe;
			assign match_v[i] = cif.match;
			assign cap_v[i] = cif.cap;
			assign rise_v[i] = cif.rise;
			assign fall_v[i] = cif.fall;
			assign evt_v[i] = cif.match || cif.cap;

			pin_func_unit #(.CW(CNT_W)) u_unit
			(
				.clk   (clk),
				.rst_b (rst_b),
				.cif   (cif)
			);
		end
	endgenerate

	assign ch0_pin_d_out = pin_v[0];
	assign ch0_pin_d_oe = oe_v[0];
	assign ch1_pin_b_out = pin_v[1];
	assign ch1_pin_b_oe = oe_v[1];

	// The read mux works on registered address so a write just before is seen.
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (dp_addr_r == OFS_CH0_CTRL)
			rd_mux = 32'(ctrl_r[0]);
		else if (dp_addr_r == OFS_CH1_CTRL)
			rd_mux = 32'(ctrl_r[1]);
		else if (dp_addr_r == OFS_RUN_CTRL)
			rd_mux = 32'(run_r);
		else if (dp_addr_r == OFS_CH0_GEN)
			rd_mux = 32'(gen_v[0]);
		else if (dp_addr_r == OFS_CH1_GEN)
			rd_mux = 32'(gen_v[1]);
		else if (dp_addr_r == OFS_EVT_STAT)
			rd_mux = 32'(stat_r);
		else if (dp_addr_r == OFS_EVT_EN)
			rd_mux = 32'(en_r);
		else if (dp_addr_r == OFS_PIN_STAT)
			rd_mux = 32'({sync2_r, pin_v});
	end

	assign hrdata = dp_rd_r ? rd_mux : 32'h0000_0000;

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!rst_b);

	sequence s_ctrl0_write;
		dp_wr_r && dp_addr_r == OFS_CH0_CTRL;
	endsequence

	sequence s_ch0_buffered;
		run_r[RB_BUF] [*2];
	endsequence

	chk_ctrl_write_lands: assert property (s_ctrl0_write |=> ctrl_r[0] == $past(hwdata[7:0]))
		else $error("Pin control register did not take written value.");

	chk_buffer_no_events: assert property (s_ch0_buffered |-> !match_v[0] && !cap_v[0])
		else $error("Buffered D register produced an event.");

	chk_buffer_pin_hold: assert property (run_r[RB_BUF] |=> $stable(pin_v[0]))
		else $error("Buffered D register moved its pin.");

	chk_d_internal_cap: assert property (func_v[0][3:2] == FC_INT && ch1_count_tick
		&& !run_r[RB_BUF] |=> gen_v[0] == $past(ch0_count))
		else $error("D register missed capture on channel 1 count step.");

	chk_b_internal_cap: assert property (func_v[1][3:2] == FC_INT && ch0_c_event
		|=> gen_v[1] == $past(ch1_count))
		else $error("B register missed capture on channel 0 C event.");

	generate
		for (genvar i = 0; i < CH_N; i++)
		begin : g_chk
			chk_retain_hold: assert property (!func_v[i][3] && func_v[i][1:0] == ACT_RETAIN
				|=> pin_v[i] == $past(pin_v[i]))
				else $error("Pin moved under a retain code.");

			chk_match_low: assert property (match_v[i] && func_v[i][1:0] == ACT_LOW
				|=> !pin_v[i] ##1 !pin_v[i] || match_v[i])
				else $error("Pin not low after compare match.");

			chk_match_high: assert property (match_v[i] && func_v[i][1:0] == ACT_HIGH
				|=> pin_v[i])
				else $error("Pin not high after compare match.");

			chk_match_toggle: assert property (match_v[i] && func_v[i][1:0] == ACT_TOGGLE
				|=> pin_v[i] != $past(pin_v[i]))
				else $error("Pin did not invert on compare match.");

			chk_init_level: assert property (!start_v[i] && !func_v[i][3] && !inh_v[i]
				&& func_v[i][1:0] != ACT_RETAIN |=> pin_v[i] == $past(func_v[i][2]))
				else $error("Initial level not applied while stopped.");

			chk_rise_capture: assert property (func_v[i] == FC_RISE && rise_v[i] && !inh_v[i]
				|=> gen_v[i] == $past(count_v[i]))
				else $error("Rising edge capture missed.");

			chk_fall_capture: assert property (func_v[i] == FC_FALL && fall_v[i] && !inh_v[i]
				|=> gen_v[i] == $past(count_v[i]))
				else $error("Falling edge capture missed.");

			chk_both_capture: assert property (func_v[i][3:1] == FC_BOTH && !inh_v[i]
				&& (rise_v[i] || fall_v[i]) |=> gen_v[i] == $past(count_v[i]))
				else $error("Both edge capture missed.");

			chk_capture_no_drive: assert property (func_v[i][3] |-> !oe_v[i])
				else $error("Pin driven in capture mode.");

			chk_event_flag: assert property (match_v[i] || cap_v[i] |=> stat_r[i])
				else $error("Event flag not set one clock after event.");
		end
	endgenerate

endmodule

`default_nettype wire

// [verilog/timer_pin_pkg.sv]
// Purpose: Shared constants and types for the timer pin function control block.
// Assumes: 32-bit AHB-Lite register bus, single word transfers only.
// Notes:   Offsets are byte addresses of aligned words.

package timer_pin_pkg;

	localparam int CNT_W = 16;
	localparam int CH_N = 2;
	localparam int CTRL_W = 8;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] OFS_CH0_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CH1_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RUN_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CH0_GEN = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CH1_GEN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_EVT_CLR = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_EVT_EN = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 8'h20;

	localparam int FUNC_LSB = 4;
	localparam int FUNC_MSB = 7;
	localparam int FB_CAPTURE = 3;
	localparam int FB_INIT = 2;
	localparam int FB_INT_SRC = 2;
	localparam int FB_BOTH = 1;
	localparam int FB_FALL = 0;
	localparam logic [3:0] FC_RISE = 4'h8;
	localparam logic [3:0] FC_FALL = 4'h9;
	localparam logic [2:0] FC_BOTH = 3'h5;
	localparam logic [1:0] FC_INT = 2'h3;

	localparam int RUN_W = 3;
	localparam int RB_START0 = 0;
	localparam int RB_START1 = 1;
	localparam int RB_BUF = 2;

	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [RUN_W-1:0] RUN_RST = 3'h0;
	localparam logic [CH_N-1:0] EVT_RST = 2'h0;
	localparam logic [CNT_W-1:0] GEN_RST = 16'h0000;

	localparam int HTRANS_ACT = 1;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	typedef enum logic [1:0]
	{
		ACT_RETAIN = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOGGLE = 2'h3
	} out_act_t;

endpackage

// [verilog/chan_if.sv]
// Purpose: Signals between the register block and one pin function unit.
// Assumes: Both ends share one clock.
// Notes:   Match, rise and fall strobes are one cycle wide; an internal source capture lasts as long as int_src.
`timescale 1ns/1ps
`default_nettype none

interface chan_if #(parameter int CW = 16);
	logic [3:0]    func;
	logic          start;
	logic          inhibit;
	logic [CW-1:0] count;
	logic          int_src;
	logic          lvl;
	logic          gen_we;
	logic [CW-1:0] gen_wdata;
	logic [CW-1:0] gen_q;
	logic          pin_q;
	logic          pin_oe;
	logic          match;
	logic          cap;
	logic          rise;
	logic          fall;

	modport top (output func, start, inhibit, count, int_src, lvl, gen_we, gen_wdata,
		input gen_q, pin_q, pin_oe, match, cap, rise, fall);
	modport unit (input func, start, inhibit, count, int_src, lvl, gen_we, gen_wdata,
		output gen_q, pin_q, pin_oe, match, cap, rise, fall);
endinterface

`default_nettype wire

// [verilog/pin_func_unit.sv]
// Purpose: Compare and capture logic for one general register and its pin.
// Assumes: Pin level arrives already synchronised.
// Notes:   Capture wins over a software write in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module pin_func_unit
	import timer_pin_pkg::*;
#(
	parameter int CW = CNT_W
)
(
	input  wire logic clk,
	input  wire logic rst_b,
	chan_if.unit      cif
);

	out_act_t      act;
	logic          is_cap;
	logic          eq;
	logic          eq_d_r;
	logic          lvl_d_r;
	logic          pin_r;
	logic [CW-1:0] gen_r;

	assign act = out_act_t'(cif.func[1:0]);
	assign is_cap = cif.func[FB_CAPTURE];
	assign eq = cif.start && (cif.count == gen_r);

	// single match pulse
	// A held count would otherwise toggle the pin on every clock.
	assign cif.match = !is_cap && !cif.inhibit && eq && !eq_d_r;
	assign cif.rise = cif.lvl && !lvl_d_r;
	assign cif.fall = !cif.lvl && lvl_d_r;

	always_comb
	begin
		cif.cap = 1'b0;
		if (is_cap && !cif.inhibit)
		begin
			if (cif.func[FB_INT_SRC])
				cif.cap = cif.int_src;
			else if (cif.func[FB_BOTH])
				cif.cap = cif.rise || cif.fall;
			else if (cif.func[FB_FALL])
				cif.cap = cif.fall;
			else
				cif.cap = cif.rise;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			eq_d_r <= 1'b0;
			lvl_d_r <= 1'b0;
		end
		else
		begin
			eq_d_r <= eq;
			lvl_d_r <= cif.lvl;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_r <= 1'b0;
		else if (!is_cap && !cif.inhibit && act != ACT_RETAIN)
		begin
			if (!cif.start)
				pin_r <= cif.func[FB_INIT];
			else if (cif.match)
			begin
				case (act)
					ACT_LOW: pin_r <= 1'b0;
					ACT_HIGH: pin_r <= 1'b1;
					default: pin_r <= !pin_r;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			gen_r <= CW'(GEN_RST);
		else if (cif.cap)
			gen_r <= cif.count;
		else if (cif.gen_we)
			gen_r <= cif.gen_wdata;
	end

	assign cif.gen_q = gen_r;
	assign cif.pin_q = pin_r;
	assign cif.pin_oe = !is_cap;

endmodule

`default_nettype wire

// [test/timer_partner.sv]
// Purpose: Model of the timer pins and of the neighbouring channel counters.
// Assumes: One clock; both counters wrap after 64 steps to keep runs short.
// Notes:   A pin reads back the design's own level while the design drives it.
`timescale 1ns/1ps
`default_nettype none

module timer_partner
	import timer_pin_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             run,
	input  wire logic             step,
	input  wire logic             lvl0,
	input  wire logic             lvl1,
	input  wire logic             out0,
	input  wire logic             oe0,
	input  wire logic             out1,
	input  wire logic             oe1,
	output logic      [CNT_W-1:0] count0,
	output logic      [CNT_W-1:0] count1,
	output logic                  tick,
	output logic                  pin0,
	output logic                  pin1
);
	// Channel 0 only moves on run, so a single step gives a known capture value.
	assign tick = run | step;
	assign pin0 = oe0 ? out0 : lvl0;
	assign pin1 = oe1 ? out1 : lvl1;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count0 <= GEN_RST;
			count1 <= GEN_RST;
		end
		else
		begin
			if (run)
				count0 <= (count0 + 16'h0001) & 16'h003f;
			if (tick)
				count1 <= (count1 + 16'h0001) & 16'h003f;
		end
	end
endmodule

`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the timer pin function control block.
// Assumes: Zero wait state slave, but every bus wait is driven by hready.
// Notes:   Counters are stopped for captures so the latched value is exact.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import timer_pin_pkg::*;
;
	logic             clk, rst_b, hsel, hwrite, hready, run, step, cev, lvl0, lvl1, e;
	logic [31:0]      haddr, hwdata, hrdata, got;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic             hreadyout, hresp, out0, oe0, out1, oe1, irq, tick, pin0, pin1;
	logic [CNT_W-1:0] count0, count1, v;
	logic [7:0]       oc [6] = '{8'h10, 8'h20, 8'h30, 8'h50, 8'h60, 8'h70};
	logic [7:0]       cc [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
	int               failures, total_checks;

	assign hready = hreadyout;

	timer_pin_io_control DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch0_count(count0),
		.ch1_count(count1), .ch1_count_tick(tick), .ch0_c_event(cev), .ch0_pin_d_in(pin0),
		.ch0_pin_d_out(out0), .ch0_pin_d_oe(oe0), .ch1_pin_b_in(pin1),
		.ch1_pin_b_out(out1), .ch1_pin_b_oe(oe1), .irq(irq));

	timer_partner far_side (.clk(clk), .rst_b(rst_b), .run(run), .step(step), .lvl0(lvl0),
		.lvl1(lvl1), .out0(out0), .oe0(oe0), .out1(out1), .oe1(oe1), .count0(count0),
		.count1(count1), .tick(tick), .pin0(pin0), .pin1(pin1));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] g);
		total_checks++;
		if (g !== ex)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, ex, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One single word transfer; read data is taken at the edge ending the data phase.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		got = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] ex);
		acc(1'b0, a, 32'h0);
		chk(what, ex, got);
		chk("okay response", 32'h0, {31'h0, hresp});
	endtask

	task automatic wait_cnt(input logic [CNT_W-1:0] c);
		for (int n = 0; n < 200 && count1 !== c; n++)
			@(posedge clk);
	endtask

	task automatic halt;
		wr(OFS_RUN_CTRL, 32'h0);
		run <= 1'b0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end

	initial
	begin
		{rst_b, hsel, hwrite, run, step, cev, lvl0, lvl1} = 8'h00;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = SIZE_WORD;
		failures = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk("pins after reset", 32'hc, {28'h0, oe1, oe0, out1, out0});
		for (int a = 0; a <= 'h24; a += 4)
			rdc("reset value", a[7:0], 32'h0);
		wr(OFS_CH0_CTRL, 32'hffff_ff1a);
		rdc("ch0 ctrl", OFS_CH0_CTRL, 32'h1a);
		wr(8'h24, 32'hffff_ffff);
		rdc("unmapped", 8'h24, 32'h0);
		foreach (oc[i])
		begin
			halt();
			wr(OFS_CH1_CTRL, {24'h0, oc[i]});
			cyc(3);
			chk("initial level", {31'h0, oc[i][6]}, {31'h0, out1});
			wr(OFS_CH1_GEN, 32'h14);
			wr(OFS_RUN_CTRL, 32'h2);
			run <= 1'b1;
			cyc(2);
			wait_cnt(16'h14);
			cyc(3);
			e = (oc[i][5:4] == 2'h3) ? ~oc[i][6] : oc[i][5];
			chk("level after match", {31'h0, e}, {31'h0, out1});
			if (oc[i][5:4] == 2'h3)
			begin
				wait_cnt(16'h14);
				cyc(3);
				chk("second toggle", {31'h0, oc[i][6]}, {31'h0, out1});
			end
		end
		wr(OFS_CH1_CTRL, 32'h10);
		cyc(3);
		chk("no initial while running", 32'h1, {31'h0, out1});
		wr(OFS_CH1_CTRL, 32'h00);
		halt();
		cyc(3);
		chk("retain high", 32'h1, {31'h0, out1});
		wr(OFS_CH1_CTRL, 32'h10);
		wr(OFS_CH1_CTRL, 32'h40);
		cyc(3);
		chk("retain low", 32'h0, {31'h0, out1});
		v = count0;
		foreach (cc[i])
		begin
			wr(OFS_CH0_CTRL, {24'h0, cc[i]});
			cyc(4);
			chk("capture pin released", 32'h0, {31'h0, oe0});
			for (int k = 0; k < 2; k++)
			begin
				wr(OFS_CH0_GEN, 32'hffff);
				lvl0 <= ~lvl0;
				cyc(8);
				e = cc[i][5] | (cc[i][4] == k[0]);
				rdc("pin capture", OFS_CH0_GEN, e ? {16'h0, v} : 32'hffff);
			end
		end
		wr(OFS_CH0_CTRL, 32'hc0);
		wr(OFS_EVT_CLR, 32'h3);
		wr(OFS_EVT_EN, 32'h0);
		for (int b = 0; b < 2; b++)
		begin
			wr(OFS_RUN_CTRL, {29'h0, b[0], 2'h0});
			wr(OFS_CH0_GEN, 32'hffff);
			// The D register latches its own channel counter; the tick only triggers it.
			v = count0;
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			cyc(3);
			rdc("step capture", OFS_CH0_GEN, b ? 32'hffff : {16'h0, v});
			rdc("event status", OFS_EVT_STAT, b ? 32'h0 : 32'h1);
			wr(OFS_EVT_CLR, 32'h3);
		end
		wr(OFS_CH1_CTRL, 32'hc0);
		wr(OFS_CH1_GEN, 32'hffff);
		cev <= 1'b1;
		@(posedge clk);
		cev <= 1'b0;
		cyc(3);
		rdc("c event capture", OFS_CH1_GEN, {16'h0, count1});
		rdc("event status", OFS_EVT_STAT, 32'h2);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_EVT_EN, 32'h2);
		cyc(2);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(OFS_EVT_CLR, 32'h2);
		cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdc("status cleared", OFS_EVT_STAT, 32'h0);
		give_verdict();
	end
endmodule

`default_nettype wire
